// file: logic/cbs_pkg.sv
// Purpose: constants shared by the CAN buffer, status and bit-timing block
// Assumes: one module clock, plain register port with one-cycle read latency
// Notes:   word offsets are byte addresses
package cbs_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_CTRL     = 8'h04;
    localparam logic [7:0] OFS_TIMING   = 8'h08;
    localparam logic [7:0] OFS_COUNTERS = 8'h0C;
    localparam logic [7:0] OFS_MASK0    = 8'h10;
    localparam logic [7:0] OFS_MASK1    = 8'h14;
    localparam logic [7:0] OFS_FILT0    = 8'h18;
    localparam logic [7:0] OFS_FILT1    = 8'h1C;
    localparam logic [7:0] OFS_TXCON0   = 8'h20;
    localparam logic [7:0] OFS_TXDATA0  = 8'h40;
    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int BIT_RX0_RECEIVED = 0;
    localparam int BIT_RX1_RECEIVED = 1;
    localparam int BIT_TX0_EMPTY    = 2;
    localparam int BIT_ERR_SUMMARY  = 5;
    localparam int BIT_INVALID_MSG  = 7;
    localparam int BIT_WAKE         = 6;
    localparam int BIT_RX_WARN      = 9;
    localparam int BIT_TX_WARN      = 10;
    localparam int BIT_RX_PASSIVE   = 11;
    localparam int BIT_TX_PASSIVE   = 12;
    localparam int BIT_BUS_OFF      = 13;
    localparam int BIT_RX1_OVR      = 14;
    localparam int BIT_RX0_OVR      = 15;
    // control register bits
    localparam int BIT_DBL_BUF      = 0;
    localparam int BIT_TX_IE        = 1;
    localparam int BIT_ABORT_ALL    = 12;
    // transmit control bits
    localparam int BIT_TX_REQUEST_BIT        = 3;
    localparam int BIT_TX_ERROR_FLAG        = 4;
    localparam int BIT_TX_ARBITRATION_LOST_FLAG       = 5;
    localparam int BIT_TX_ABORTED_FLAG        = 6;
    // ------------------------------------------------------------
    // limits and reset values
    // ------------------------------------------------------------
    localparam logic [8:0] WARN_LIMIT    = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;
    localparam int         TQ_MIN        = 8;
    localparam int         TQ_MAX        = 25;
    localparam logic [31:0] RST_TIMING   = 32'h0000_0000;
    localparam int         TX_BYTES      = 14;
    localparam int         NUM_TX        = 3;
    localparam int         ID_W          = 29;
endpackage

// file: logic/cbs_core.sv
// Purpose: receive buffer status, transmit buffers, error counters, quantum clock
// Assumes: protocol engine reports frame events as one-cycle pulses
// Notes:   single module clock, no clock enable
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cbs_core #(
    parameter int ID_W = 29
) (
    input  wire logic            i_mclk,
    input  wire logic            i_rst,
    input  wire logic [7:0]      i_addr,
    input  wire logic [31:0]     i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [31:0]     o_rdata,
    input  wire logic            i_rx_done,
    input  wire logic [ID_W-1:0] i_rx_id,
    input  wire logic            i_rx_err,
    input  wire logic            i_tx_sof,
    input  wire logic            i_tx_ok,
    input  wire logic            i_tx_err,
    input  wire logic            i_tx_arb_lost,
    input  wire logic            i_wake,
    output logic                 o_tx_valid,
    output logic      [1:0]      o_tx_sel,
    output logic                 o_tq_tick,
    output logic                 o_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]     status, next_status;
    logic [1:0]      rx_full, next_rx_full;
    logic [1:0]      ctrl, next_ctrl;
    logic [5:0]      presc, next_presc;
    logic [ID_W-1:0] mask [2];
    logic [ID_W-1:0] filt [2];
    logic [6:0]      txcon [3];
    logic [6:0]      next_txcon [3];
    logic [7:0]      txmem [3][14];
    logic [8:0]      rec, next_rec, tec, next_tec;
    logic [1:0]      act, next_act;
    logic            busy, next_busy;
    logic [6:0]      pcnt, next_pcnt;
    logic            tqt, next_tqt;
    logic [31:0]     rdata;
    logic [1:0]      best;
    logic            any_req;
    logic            hit0, hit1;
    logic [7:0]      wbyte;
    logic [4:0]      bitq, bitq_w;

    // ------------------------------------------------------------
    // acceptance and priority
    // ------------------------------------------------------------
    assign hit0 = ((i_rx_id ^ filt[0]) & mask[0]) == '0;
    assign hit1 = ((i_rx_id ^ filt[1]) & mask[1]) == '0;
    assign wbyte = i_wdata[7:0];
    assign bitq_w = (i_wdata[12:8] < 5'(cbs_pkg::TQ_MIN)) ? 5'(cbs_pkg::TQ_MIN) :
                    (i_wdata[12:8] > 5'(cbs_pkg::TQ_MAX)) ? 5'(cbs_pkg::TQ_MAX) : i_wdata[12:8];

    always_comb
    begin
        best    = 2'd0;
        any_req = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            if (txcon[i][cbs_pkg::BIT_TX_REQUEST_BIT] && (!any_req || txcon[i][1:0] > txcon[best][1:0]))
            begin
                best    = 2'(i);
                any_req = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_status = status;
        next_rx_full = rx_full;
        next_ctrl   = ctrl;
        next_presc  = presc;
        next_rec    = rec;
        next_tec    = tec;
        next_act    = act;
        next_busy   = busy;
        for (int i = 0; i < 3; i++)
        begin
            next_txcon[i] = txcon[i];
        end
        // software writes; hardware sets below win over clears
        if (i_wr)
        begin
            case (i_addr)
                cbs_pkg::OFS_STATUS:
                begin
                    next_status = status & ~i_wdata[15:0];
                    if (i_wdata[cbs_pkg::BIT_RX0_RECEIVED]) next_rx_full[0] = 1'b0;
                    if (i_wdata[cbs_pkg::BIT_RX1_RECEIVED]) next_rx_full[1] = 1'b0;
                end
                cbs_pkg::OFS_CTRL:
                begin
                    next_ctrl = i_wdata[1:0];
                    if (i_wdata[cbs_pkg::BIT_ABORT_ALL])
                    begin
                        for (int i = 0; i < 3; i++)
                        begin
                            if (txcon[i][cbs_pkg::BIT_TX_REQUEST_BIT] && !(busy && act == 2'(i)))
                            begin
                                next_txcon[i][cbs_pkg::BIT_TX_REQUEST_BIT] = 1'b0;
                                next_txcon[i][cbs_pkg::BIT_TX_ABORTED_FLAG] = 1'b1;
                            end
                        end
                    end
                end
                cbs_pkg::OFS_TIMING: next_presc = i_wdata[5:0];
                default:
                begin
                    for (int i = 0; i < 3; i++)
                    begin
                        if (i_addr == cbs_pkg::OFS_TXCON0 + 8'(4 * i))
                        begin
                            next_txcon[i][1:0] = i_wdata[1:0];
                            if (i_wdata[cbs_pkg::BIT_TX_REQUEST_BIT])
                            begin
                                next_txcon[i][cbs_pkg::BIT_TX_REQUEST_BIT] = 1'b1;
                                next_txcon[i][6:4] = 3'h0;
                            end
                            else if (txcon[i][cbs_pkg::BIT_TX_REQUEST_BIT] && !(busy && act == 2'(i)))
                            begin
                                next_txcon[i][cbs_pkg::BIT_TX_REQUEST_BIT] = 1'b0;
                                next_txcon[i][cbs_pkg::BIT_TX_ABORTED_FLAG] = 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
        // reception
        if (i_rx_err)
        begin
            next_rec = (rec == 9'h1FF) ? rec : rec + 9'd1;
            next_status[cbs_pkg::BIT_INVALID_MSG] = 1'b1;
            next_status[cbs_pkg::BIT_ERR_SUMMARY] = 1'b1;
        end
        else if (i_rx_done)
        begin
            if (rec != 9'd0) next_rec = rec - 9'd1;
            if (hit0)
            begin
                if (!rx_full[0])
                begin
                    next_rx_full[0] = 1'b1;
                    next_status[cbs_pkg::BIT_RX0_RECEIVED] = 1'b1;
                end
                else if (ctrl[cbs_pkg::BIT_DBL_BUF] && !rx_full[1])
                begin
                    next_rx_full[1] = 1'b1;
                    next_status[cbs_pkg::BIT_RX1_RECEIVED] = 1'b1;
                end
                else if (ctrl[cbs_pkg::BIT_DBL_BUF])
                begin
                    next_status[cbs_pkg::BIT_RX1_OVR] = 1'b1;
                    next_status[cbs_pkg::BIT_ERR_SUMMARY] = 1'b1;
                end
                else
                begin
                    next_status[cbs_pkg::BIT_RX0_OVR] = 1'b1;
                    next_status[cbs_pkg::BIT_ERR_SUMMARY] = 1'b1;
                end
            end
            else if (hit1)
            begin
                if (!rx_full[1])
                begin
                    next_rx_full[1] = 1'b1;
                    next_status[cbs_pkg::BIT_RX1_RECEIVED] = 1'b1;
                end
                else
                begin
                    next_status[cbs_pkg::BIT_RX1_OVR] = 1'b1;
                    next_status[cbs_pkg::BIT_ERR_SUMMARY] = 1'b1;
                end
            end
        end
        // transmission
        if (i_tx_sof && any_req && !status[cbs_pkg::BIT_BUS_OFF])
        begin
            next_busy = 1'b1;
            next_act  = best;
        end
        if (busy && (i_tx_ok || i_tx_err || i_tx_arb_lost))
        begin
            next_busy = 1'b0;
            if (i_tx_ok)
            begin
                next_txcon[act][cbs_pkg::BIT_TX_REQUEST_BIT] = 1'b0;
                if (tec != 9'd0) next_tec = tec - 9'd1;
            end
            else if (i_tx_err)
            begin
                next_txcon[act][cbs_pkg::BIT_TX_ERROR_FLAG] = 1'b1;
                next_tec = (tec == 9'h1FF) ? tec : tec + 9'd1;
            end
            else
            begin
                next_txcon[act][cbs_pkg::BIT_TX_ARBITRATION_LOST_FLAG] = 1'b1;
            end
        end
        // counter thresholds
        if (next_rec >= cbs_pkg::WARN_LIMIT) next_status[cbs_pkg::BIT_RX_WARN] = 1'b1;
        if (next_rec > cbs_pkg::PASSIVE_LIMIT) next_status[cbs_pkg::BIT_RX_PASSIVE] = 1'b1;
        if (next_tec > cbs_pkg::WARN_LIMIT)
        begin
            next_status[cbs_pkg::BIT_TX_WARN] = 1'b1;
            next_status[cbs_pkg::BIT_ERR_SUMMARY] = 1'b1;
        end
        if (next_tec > cbs_pkg::PASSIVE_LIMIT) next_status[cbs_pkg::BIT_TX_PASSIVE] = 1'b1;
        if (next_tec > cbs_pkg::BUSOFF_LIMIT) next_status[cbs_pkg::BIT_BUS_OFF] = 1'b1;
        if (i_wake) next_status[cbs_pkg::BIT_WAKE] = 1'b1;
        // empty-buffer flags follow request and aborted bits
        for (int i = 0; i < 3; i++)
        begin
            next_status[cbs_pkg::BIT_TX0_EMPTY + i] = !next_txcon[i][cbs_pkg::BIT_TX_REQUEST_BIT] &&
                                                      !next_txcon[i][cbs_pkg::BIT_TX_ABORTED_FLAG];
        end
        // quantum prescaler: period 2*(presc+1) cycles
        next_pcnt = pcnt + 7'd1;
        next_tqt  = 1'b0;
        if (pcnt >= {presc, 1'b1})
        begin
            next_pcnt = 7'd0;
            next_tqt  = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            status  <= 16'h001C;
            rx_full <= 2'h0;
            ctrl    <= 2'h0;
            presc   <= 6'h00;
            rec     <= 9'h000;
            tec     <= 9'h000;
            act     <= 2'h0;
            busy    <= 1'b0;
            pcnt    <= 7'h00;
            tqt     <= 1'b0;
            for (int i = 0; i < 3; i++)
            begin
                txcon[i] <= 7'h00;
            end
        end
        else
        begin
            status  <= next_status;
            rx_full <= next_rx_full;
            ctrl    <= next_ctrl;
            presc   <= next_presc;
            rec     <= next_rec;
            tec     <= next_tec;
            act     <= next_act;
            busy    <= next_busy;
            pcnt    <= next_pcnt;
            tqt     <= next_tqt;
            for (int i = 0; i < 3; i++)
            begin
                txcon[i] <= next_txcon[i];
            end
        end
    end
    // masks, filters, bit length and 14-byte transmit buffers, no reset needed
    always_ff @(posedge i_mclk)
    begin
        if (i_wr && i_addr == cbs_pkg::OFS_TIMING) bitq <= bitq_w;
        if (i_wr && i_addr == cbs_pkg::OFS_MASK0) mask[0] <= i_wdata[ID_W-1:0];
        if (i_wr && i_addr == cbs_pkg::OFS_MASK1) mask[1] <= i_wdata[ID_W-1:0];
        if (i_wr && i_addr == cbs_pkg::OFS_FILT0) filt[0] <= i_wdata[ID_W-1:0];
        if (i_wr && i_addr == cbs_pkg::OFS_FILT1) filt[1] <= i_wdata[ID_W-1:0];
        for (int b = 0; b < 3; b++)
        begin
            for (int j = 0; j < 14; j++)
            begin
                if (i_wr && i_addr == cbs_pkg::OFS_TXDATA0 + 8'(16 * b + j)) txmem[b][j] <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (i_addr)
            cbs_pkg::OFS_STATUS:   rdata = {16'h0000, status};
            cbs_pkg::OFS_CTRL:     rdata = {30'h0, ctrl};
            cbs_pkg::OFS_TIMING:   rdata = {19'h0, bitq, 2'h0, presc};
            cbs_pkg::OFS_COUNTERS: rdata = {7'h0, tec, 7'h0, rec};
            cbs_pkg::OFS_MASK0:    rdata = 32'(mask[0]);
            cbs_pkg::OFS_MASK1:    rdata = 32'(mask[1]);
            cbs_pkg::OFS_FILT0:    rdata = 32'(filt[0]);
            cbs_pkg::OFS_FILT1:    rdata = 32'(filt[1]);
            default:
            begin
                for (int i = 0; i < 3; i++)
                begin
                    if (i_addr == cbs_pkg::OFS_TXCON0 + 8'(4 * i)) rdata = {25'h0, txcon[i]};
                    for (int j = 0; j < 14; j++)
                    begin
                        if (i_addr == cbs_pkg::OFS_TXDATA0 + 8'(16 * i + j)) rdata = {24'h0, txmem[i][j]};
                    end
                end
            end
        endcase
    end
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata <= 32'h0000_0000;
        end
        else
        begin
            o_rdata <= i_rd ? rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_tx_valid = busy;
    assign o_tx_sel   = act;
    assign o_tq_tick  = tqt;
    assign o_irq = status[cbs_pkg::BIT_RX0_RECEIVED] | status[cbs_pkg::BIT_RX1_RECEIVED] |
                   status[cbs_pkg::BIT_WAKE] | status[cbs_pkg::BIT_ERR_SUMMARY] |
                   (ctrl[cbs_pkg::BIT_TX_IE] & |status[4:2]);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_overrun0;
        @(posedge i_mclk) disable iff (i_rst)
        (i_rx_done && !i_rx_err && hit0 && rx_full[0] && !ctrl[0]) |=> status[15] && status[5];
    endproperty
    a_overrun0: assert property (p_overrun0) else $error("buffer 0 overrun not flagged");
    property p_divert;
        @(posedge i_mclk) disable iff (i_rst)
        (i_rx_done && !i_rx_err && hit0 && rx_full[0] && !rx_full[1] && ctrl[0] && !i_wr)
            |=> rx_full[1] && !status[15];
    endproperty
    a_divert: assert property (p_divert) else $error("double buffer divert failed");
    property p_rxerr;
        @(posedge i_mclk) disable iff (i_rst)
        (i_rx_err && rec < 9'h1FF) |=> rec == $past(rec) + 9'd1 && status[7];
    endproperty
    a_rxerr: assert property (p_rxerr) else $error("receive error not counted");
    property p_rxwarn;
        @(posedge i_mclk) disable iff (i_rst)
        (rec >= 9'd96 && !i_wr) |-> ##1 status[9];
    endproperty
    a_rxwarn: assert property (p_rxwarn) else $error("receive warning missing");
    property p_req_clear;
        @(posedge i_mclk) disable iff (i_rst)
        (i_wr && i_addr == 8'h20 && i_wdata[3] && !busy) |=> txcon[0][6:4] == 3'h0;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request did not clear flags");
    property p_txok;
        @(posedge i_mclk) disable iff (i_rst)
        (busy && i_tx_ok && !i_wr) |=> !txcon[act][3] && !busy;
    endproperty
    a_txok: assert property (p_txok) else $error("success did not clear request");
    property p_arb;
        @(posedge i_mclk) disable iff (i_rst)
        (busy && i_tx_arb_lost && !i_tx_ok && !i_tx_err && !i_wr) |=> txcon[act][5] && txcon[act][3];
    endproperty
    a_arb: assert property (p_arb) else $error("arbitration loss mishandled");
    property p_busoff;
        @(posedge i_mclk) disable iff (i_rst)
        (tec > 9'd255) |-> ##1 status[13] && status[12];
    endproperty
    a_busoff: assert property (p_busoff) else $error("bus-off not flagged");
    property p_tq;
        @(posedge i_mclk) disable iff (i_rst)
        (tqt && presc == 6'd0 && !i_wr) |-> ##2 tqt;
    endproperty
    a_tq: assert property (p_tq) else $error("quantum period wrong");
    c_rx0: cover property (@(posedge i_mclk) i_rx_done && hit0 && !rx_full[0]);
    c_ovr1: cover property (@(posedge i_mclk) status[14]);
    c_txok: cover property (@(posedge i_mclk) busy && i_tx_ok);
endmodule
`default_nettype wire

// file: sim/cbs_node_model.sv
// Purpose: far-side node model driving frame events
// Assumes: events are one-cycle pulses launched after a rising edge
// Notes:   released id lines show the inverse of the last id
`timescale 1ns/100ps
`default_nettype none
module cbs_node_model (
    input  wire logic        i_mclk,
    input  wire logic        i_tx_valid,
    input  wire logic [1:0]  i_tx_sel,
    output logic             o_rx_done = 1'b0,
    output logic      [28:0] o_rx_id = 29'h0,
    output logic             o_rx_err = 1'b0,
    output logic             o_tx_sof = 1'b0,
    output logic      [2:0]  o_tx_res = 3'h0,
    output logic             o_wake = 1'b0
);
    logic [1:0] sel_seen;
    // ------------------------------------------------------------
    // frame events
    // ------------------------------------------------------------
    task automatic frame(input logic [28:0] id, input logic bad);
        @(posedge i_mclk);
        o_rx_id <= id;
        o_rx_done <= ~bad;
        o_rx_err <= bad;
        @(posedge i_mclk);
        o_rx_id <= ~id;
        o_rx_done <= 1'b0;
        o_rx_err <= 1'b0;
    endtask
    // result 0 ok, 1 error, 2 lost arbitration
    task automatic attempt(input int res);
        @(posedge i_mclk);
        o_tx_sof <= 1'b1;
        @(posedge i_mclk);
        o_tx_sof <= 1'b0;
        #1 sel_seen = i_tx_valid ? i_tx_sel : 2'h3;
        @(posedge i_mclk);
        o_tx_res <= 3'h1 << res;
        @(posedge i_mclk);
        o_tx_res <= 3'h0;
    endtask
    task automatic wake;
        @(posedge i_mclk);
        o_wake <= 1'b1;
        @(posedge i_mclk);
        o_wake <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: sim/can_buffer_status_and_bit_timing_bench.sv
// Purpose: self-checking bench for cbs_core
// Assumes: node model drives the frame event pins
// Notes:   fixed seed, random ids, priorities and prescaler
`timescale 1ns/100ps
`default_nettype none
module can_buffer_status_and_bit_timing_bench;
    localparam logic [7:0] ST = cbs_pkg::OFS_STATUS;
    localparam logic [7:0] CNT = cbs_pkg::OFS_COUNTERS;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic        rxd, rxe, sof, wk, o_tx_valid, o_tq_tick, o_irq;
    logic [28:0] rxid;
    logic [2:0]  tres;
    logic [1:0]  o_tx_sel;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          seed = 32'h288C;
    int          r, w, n, p;
    logic [28:0] id;
    logic [31:0] d;
    cbs_core i_cbs_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_done(rxd), .i_rx_id(rxid),
        .i_rx_err(rxe), .i_tx_sof(sof), .i_tx_ok(tres[0]), .i_tx_err(tres[1]),
        .i_tx_arb_lost(tres[2]), .i_wake(wk), .o_tx_valid(o_tx_valid), .o_tx_sel(o_tx_sel),
        .o_tq_tick(o_tq_tick), .o_irq(o_irq));
    cbs_node_model m (.i_mclk(i_mclk), .i_tx_valid(o_tx_valid), .i_tx_sel(o_tx_sel),
        .o_rx_done(rxd), .o_rx_id(rxid), .o_rx_err(rxe), .o_tx_sof(sof), .o_tx_res(tres),
        .o_wake(wk));
    always #4 i_mclk = ~i_mclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata & k, e);
    endtask
    function automatic logic [7:0] ta(input int b);
        ta = cbs_pkg::OFS_TXCON0 + 8'(4 * b);
    endfunction
    function automatic int win(input int q);
        win = 0;
        for (int i = 1; i < 3; i++)
            if ((q + i) % 4 > (q + win) % 4)
                win = i;
    endfunction
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        rchk(ST, 32'hFFFF, 32'h001C);
        id = 29'($random(seed));
        wr(cbs_pkg::OFS_MASK0, 32'h1FFFFFFE);
        wr(cbs_pkg::OFS_FILT0, {3'h0, id});
        wr(cbs_pkg::OFS_MASK1, 32'h1FFFFFFF);
        wr(cbs_pkg::OFS_FILT1, {3'h0, ~id});
        m.frame(id ^ 29'h2, 1'b0);
        rchk(ST, 32'h0003, 32'h0);
        m.frame(id ^ 29'h1, 1'b0);
        rchk(ST, 32'hC023, 32'h0001);
        m.frame(id, 1'b0);
        rchk(ST, 32'hC023, 32'h8021);
        wr(ST, 32'hFFFF);
        wr(cbs_pkg::OFS_CTRL, 32'h1);
        m.frame(id, 1'b0);
        m.frame(id, 1'b0);
        rchk(ST, 32'hC023, 32'h0003);
        m.frame(id, 1'b0);
        rchk(ST, 32'hC023, 32'h4023);
        wr(ST, 32'hFFFF);
        for (int i = 1; i <= 128; i++)
        begin
            m.frame(id, 1'b1);
            if (i == 95 || i == 96)
                rchk(ST, 32'h0200, (i == 96) ? 32'h0200 : 32'h0);
            if (i == 127 || i == 128)
                rchk(ST, 32'h0800, (i == 128) ? 32'h0800 : 32'h0);
        end
        rchk(ST, 32'h0080, 32'h0080);
        chk(32'(o_irq), 32'h1);
        rchk(CNT, 32'h1FF, 32'd128);
        m.frame(id, 1'b0);
        rchk(CNT, 32'h1FF, 32'd127);
        m.wake();
        rchk(ST, 32'h0040, 32'h0040);
        d = $random(seed);
        wr(cbs_pkg::OFS_TXDATA0 + 8'(16 * (cbs_pkg::NUM_TX - 1) + cbs_pkg::TX_BYTES - 1), d);
        rchk(cbs_pkg::OFS_TXDATA0 + 8'(16 * (cbs_pkg::NUM_TX - 1) + cbs_pkg::TX_BYTES - 1), 32'hFFFF_FFFF,
             {24'h0, d[7:0]});
        wr(ST, 32'hFFFF);
        wr(cbs_pkg::OFS_CTRL, 32'h2);
        r = $random(seed) & 3;
        w = win(r);
        for (int b = 0; b < 3; b++)
            wr(ta(b), 32'((r + b) % 4) | 32'h8);
        rchk(ST, 32'h001C, 32'h0);
        m.attempt(2);
        chk(32'(m.sel_seen), 32'(w));
        rchk(ta(w), 32'h78, 32'h28);
        m.attempt(1);
        rchk(ta(w), 32'h18, 32'h18);
        rchk(CNT, 32'h1FF0000, 32'h10000);
        wr(ta(w), 32'((r + w) % 4) | 32'h8);
        rchk(ta(w), 32'h78, 32'h08);
        m.attempt(0);
        rchk(ta(w), 32'h08, 32'h0);
        rchk(ST, 32'h4 << w, 32'h4 << w);
        chk(32'(o_irq), 32'h1);
        rchk(CNT, 32'h1FF0000, 32'h0);
        n = (w + 1) % 3;
        wr(ta(n), 32'((r + n) % 4));
        wr(cbs_pkg::OFS_CTRL, 32'h1002);
        for (int b = 0; b < 3; b++)
            if (b != w)
                rchk(ta(b), 32'h48, 32'h40);
        wr(ta(0), 32'h8);
        for (int i = 1; i <= 256; i++)
        begin
            m.attempt(1);
            if (i == 96 || i == 97)
                rchk(ST, 32'h0400, (i == 97) ? 32'h0400 : 32'h0);
            if (i == 127 || i == 128)
                rchk(ST, 32'h1000, (i == 128) ? 32'h1000 : 32'h0);
            if (i == 255 || i == 256)
                rchk(ST, 32'h2000, (i == 256) ? 32'h2000 : 32'h0);
        end
        for (int k = 0; k < 2; k++)
        begin
            p = k ? 63 : ($random(seed) & 63);
            wr(cbs_pkg::OFS_TIMING, {19'h0, k ? 5'h1F : 5'h03, 2'h0, 6'(p)});
            rchk(cbs_pkg::OFS_TIMING, 32'h1F00, 32'(k ? cbs_pkg::TQ_MAX : cbs_pkg::TQ_MIN) << 8);
            repeat (2) @(negedge i_mclk iff o_tq_tick === 1'b1);
            n = 0;
            do
            begin
                @(negedge i_mclk);
                n++;
            end while (o_tq_tick !== 1'b1 && n < 200);
            chk(32'(n), 32'(2 * (p + 1)));
        end
        wrap_up();
    end
endmodule
`default_nettype wire
